// file: hdl/amp_gain_mode_registers.sv
// gain and mode register bank of a stereo class-d amplifier
// assumes the serial engine hands over one whole write word per strobe and
// that the level control enable comes from the level control block
`default_nettype none

module amp_gain_mode_registers (
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic        wr_valid_in,
   input  wire logic [15:0] wr_word_in,
   input  wire logic [6:0]  rd_addr_in,
   input  wire logic        level_control_enable_in,
   output var  logic [8:0]  rd_data_out,
   output var  logic        left_channel_mute_out,
   output var  logic        right_channel_mute_out,
   output var  logic [5:0]  left_gain_code_out,
   output var  logic [5:0]  right_gain_code_out,
   output var  logic [1:0]  edge_rate_out,
   output var  logic        overcurrent_autorecovery_enable_out,
   output var  logic        overtemp_autorecovery_enable_out,
   output var  logic        right_input_to_both_mix_out,
   output var  logic        left_input_to_both_mix_out
);
   // ---------------------------------------------------------------
   // write word decode
   // ---------------------------------------------------------------
   logic [6:0] wr_addr;
   logic [8:0] wr_data;
   logic [1:0] wr_own;
   logic [1:0] wr_cross;
   logic       alc;

   assign wr_addr = wr_word_in[amp_regs_pkg::ADDR_HI:amp_regs_pkg::ADDR_LO];
   assign wr_data = wr_word_in[amp_regs_pkg::DATA_W-1:0];
   assign alc     = level_control_enable_in;

   // ---------------------------------------------------------------
   // gain registers, index 0 left and 1 right
   // ---------------------------------------------------------------
   logic [1:0] load_both_reg;
   logic [1:0] mute_reg;
   logic [5:0] gain_code_reg [2];
   logic [5:0] eff_src       [2];
   logic [5:0] eff_code      [2];

   genvar ch;
   generate
      for (ch = 0; ch < amp_regs_pkg::NUM_CH; ch++) begin : g_ch
         localparam logic [6:0] OWN_ADDR =
            (ch == 0) ? amp_regs_pkg::ADDR_LEFT : amp_regs_pkg::ADDR_RIGHT;
         localparam logic [6:0] OTHER_ADDR =
            (ch == 0) ? amp_regs_pkg::ADDR_RIGHT : amp_regs_pkg::ADDR_LEFT;

         assign wr_own[ch]   = wr_valid_in
                               && (wr_addr == OWN_ADDR);
         assign wr_cross[ch] = wr_valid_in && (wr_addr == OTHER_ADDR)
                               && wr_data[amp_regs_pkg::LOAD_BIT];

         always_ff @(posedge mclk_in) begin
            if (!nrst_in) begin
               load_both_reg[ch] <=
                  amp_regs_pkg::GAIN_RESET[amp_regs_pkg::LOAD_BIT];
               mute_reg[ch] <=
                  amp_regs_pkg::GAIN_RESET[amp_regs_pkg::MUTE_BIT];
            end else if (wr_own[ch]) begin
               load_both_reg[ch] <= wr_data[amp_regs_pkg::LOAD_BIT];
               mute_reg[ch]      <=
                  wr_data[amp_regs_pkg::MUTE_BIT];
            end
         end

         // the lock also blocks the cross load, or it could be bypassed
         always_ff @(posedge mclk_in) begin
            if (!nrst_in) begin
               gain_code_reg[ch] <=
                  amp_regs_pkg::GAIN_RESET[5:0];
            end else if (!alc
                         && (wr_own[ch] || wr_cross[ch])) begin
               gain_code_reg[ch] <=
                  wr_data[amp_regs_pkg::CODE_HI:0];
            end
         end

         // under level control the left code drives both channels
         assign eff_src[ch] = alc ? gain_code_reg[0]
                                  : gain_code_reg[ch];

         gain_effective #(
            .CODE_W (amp_regs_pkg::CODE_W)
         ) u_eff (
            .mclk_in  (mclk_in),
            .nrst_in  (nrst_in),
            .code_in  (eff_src[ch]),
            .code_out (eff_code[ch])
         );
      end
   endgenerate

   assign left_gain_code_out  = eff_code[0];
   assign right_gain_code_out = eff_code[1];

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         left_channel_mute_out  <= 1'b0;
         right_channel_mute_out <= 1'b0;
      end else begin
         left_channel_mute_out  <= mute_reg[0];
         right_channel_mute_out <= mute_reg[1];
      end
   end

   // ---------------------------------------------------------------
   // mode register
   // ---------------------------------------------------------------
   logic [7:0] mode_reg;

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         mode_reg <= amp_regs_pkg::MODE_RESET;
      end else if (wr_valid_in && (wr_addr == amp_regs_pkg::ADDR_MODE)) begin
         // top two bits are fixed, so drop whatever the host sends there
         mode_reg <= wr_data[7:0] & amp_regs_pkg::MODE_WR_MASK;
      end
   end

   assign edge_rate_out =
      mode_reg[amp_regs_pkg::EDGE_HI:amp_regs_pkg::EDGE_LO];
   assign overcurrent_autorecovery_enable_out =
      mode_reg[amp_regs_pkg::OC_REC_BIT];
   assign overtemp_autorecovery_enable_out =
      mode_reg[amp_regs_pkg::OT_REC_BIT];
   assign right_input_to_both_mix_out =
      mode_reg[amp_regs_pkg::R_MIX_BIT];
   assign left_input_to_both_mix_out  =
      mode_reg[amp_regs_pkg::L_MIX_BIT];

   // ---------------------------------------------------------------
   // read back
   // ---------------------------------------------------------------
   // one cycle latency; unmapped addresses and bit 8 read as zero
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         rd_data_out <= 9'h000;
      end else begin
         case (rd_addr_in)
            amp_regs_pkg::ADDR_LEFT:
               rd_data_out <= {1'b0, load_both_reg[0], mute_reg[0],
                               gain_code_reg[0]};
            amp_regs_pkg::ADDR_RIGHT:
               rd_data_out <= {1'b0, load_both_reg[1], mute_reg[1],
                               gain_code_reg[1]};
            amp_regs_pkg::ADDR_MODE:
               rd_data_out <= {1'b0, mode_reg};
            default:
               rd_data_out <= 9'h000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic w_left;
   logic w_right;
   logic w_mode;
   assign w_left  = wr_valid_in && (wr_addr == amp_regs_pkg::ADDR_LEFT);
   assign w_right = wr_valid_in && (wr_addr == amp_regs_pkg::ADDR_RIGHT);
   assign w_mode  = wr_valid_in && (wr_addr == amp_regs_pkg::ADDR_MODE);

   property p_left_write;
      @(posedge mclk_in) disable iff (!nrst_in)
      (w_left && !alc) |=> (gain_code_reg[0] == $past(wr_data[5:0]));
   endproperty
   a_left_write: assert property (p_left_write)
      else $error("left gain code not loaded by write");

   property p_right_write;
      @(posedge mclk_in) disable iff (!nrst_in)
      (w_right && !alc) |=> (gain_code_reg[1] == $past(wr_data[5:0]));
   endproperty
   a_right_write: assert property (p_right_write)
      else $error("right gain code not loaded by write");

   property p_left_cross;
      @(posedge mclk_in) disable iff (!nrst_in)
      (w_left && !alc && wr_data[7]) |=>
         (gain_code_reg[1] == $past(wr_data[5:0]));
   endproperty
   a_left_cross: assert property (p_left_cross)
      else $error("left write with load bit did not load right code");

   property p_no_cross;
      @(posedge mclk_in) disable iff (!nrst_in)
      (w_left && !wr_data[7]) |=> $stable(gain_code_reg[1]);
   endproperty
   a_no_cross: assert property (p_no_cross)
      else $error("left write without load bit changed right code");

   property p_left_mute;
      @(posedge mclk_in) disable iff (!nrst_in)
      w_left ##1 !w_left |=> (left_channel_mute_out == $past(wr_data[6], 2));
   endproperty
   a_left_mute: assert property (p_left_mute)
      else $error("left mute output does not follow written bit");

   property p_saturate;
      @(posedge mclk_in) disable iff (!nrst_in)
      (!alc && gain_code_reg[0] > amp_regs_pkg::GAIN_SAT) |=>
         (left_gain_code_out == amp_regs_pkg::GAIN_SAT);
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("left gain code not clamped at top step");

   property p_alc_both;
      @(posedge mclk_in) disable iff (!nrst_in)
      alc |=> (right_gain_code_out == left_gain_code_out);
   endproperty
   a_alc_both: assert property (p_alc_both)
      else $error("right gain does not follow left under level control");

   property p_lock_left;
      @(posedge mclk_in) disable iff (!nrst_in)
      alc |=> $stable(gain_code_reg[0]);
   endproperty
   a_lock_left: assert property (p_lock_left)
      else $error("left gain code changed while locked");

   property p_lock_right;
      @(posedge mclk_in) disable iff (!nrst_in)
      alc |=> $stable(gain_code_reg[1]);
   endproperty
   a_lock_right: assert property (p_lock_right)
      else $error("right gain code changed while locked");

   property p_right_cross;
      @(posedge mclk_in) disable iff (!nrst_in)
      (w_right && !alc && wr_data[7]) |=>
         (gain_code_reg[0] == $past(wr_data[5:0]));
   endproperty
   a_right_cross: assert property (p_right_cross)
      else $error("right write with load bit did not load left code");

   property p_right_mute;
      @(posedge mclk_in) disable iff (!nrst_in)
      w_right ##1 !w_right |=>
         (right_channel_mute_out == $past(wr_data[6], 2));
   endproperty
   a_right_mute: assert property (p_right_mute)
      else $error("right mute output does not follow written bit");

   property p_mode_write;
      @(posedge mclk_in) disable iff (!nrst_in)
      w_mode |=> (mode_reg == ($past(wr_data[7:0]) & 8'h3F));
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode register not loaded by write");

   property p_mode_top_zero;
      @(posedge mclk_in) disable iff (!nrst_in)
      (rd_addr_in == amp_regs_pkg::ADDR_MODE) |=> (rd_data_out[8:6] == 3'h0);
   endproperty
   a_mode_top_zero: assert property (p_mode_top_zero)
      else $error("mode register fixed bits read nonzero");

   property p_reset_defaults;
      @(posedge mclk_in)
      !nrst_in |=> (overcurrent_autorecovery_enable_out
                    && overtemp_autorecovery_enable_out
                    && !left_input_to_both_mix_out
                    && !right_input_to_both_mix_out);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("mode defaults wrong after reset");

   c_cross_load: cover property (@(posedge mclk_in) disable iff (!nrst_in)
      w_left && !alc && wr_data[7]);
   c_locked_write: cover property (@(posedge mclk_in) disable iff (!nrst_in)
      w_right && alc);
   c_saturated: cover property (@(posedge mclk_in) disable iff (!nrst_in)
      right_gain_code_out == amp_regs_pkg::GAIN_SAT);
   c_mix_both: cover property (@(posedge mclk_in) disable iff (!nrst_in)
      left_input_to_both_mix_out && right_input_to_both_mix_out);
endmodule : amp_gain_mode_registers

`default_nettype wire

// file: common/amp_regs_pkg.sv
// constants for the stereo amplifier gain and mode register bank
// assumes a serial bus engine upstream that delivers whole 16-bit words
//
// Functional notes
// - the left gain register at 0x00 holds the load bit, mute and gain code.
// - a left write with its load bit set also loads the right gain code.
// - left mute set to 1 mutes the left channel, default unmuted.
// - gain code steps 0.5 dB from 1 dB, defaults to 18 dB, saturates at 24.
// - under level control the left gain code sets both channels.
// - under level control writes cannot change the left gain code.
// - the right gain register at 0x01 holds load bit, mute and gain code.
// - a right write with its load bit set also loads the left gain code.
// - right mute set to 1 mutes the right channel, default unmuted.
// - the right gain code uses the same encoding as the left.
// - under level control writes cannot change the right gain code.
// - the mode register at 0x02 holds edge rate, recovery and mix bits.
// - a write word is 16 bits, address in 15:9 and data in 8:0.
// - each mix bit sends its input to both outputs, both default off.
// - both autorecovery enables default on and are cleared by writing 0.
`default_nettype none

package amp_regs_pkg;
   localparam int        WORD_W        = 16;
   localparam int        ADDR_HI       = 15;
   localparam int        ADDR_LO       = 9;
   localparam int        ADDR_W        = 7;
   localparam int        DATA_W        = 9;
   localparam int        REG_W         = 8;
   localparam int        CODE_W        = 6;
   localparam int        NUM_CH        = 2;
   localparam logic [6:0] ADDR_LEFT    = 7'h00;
   localparam logic [6:0] ADDR_RIGHT   = 7'h01;
   localparam logic [6:0] ADDR_MODE    = 7'h02;
   localparam int        LOAD_BIT      = 7;
   localparam int        MUTE_BIT      = 6;
   localparam int        CODE_HI       = 5;
   localparam int        EDGE_HI       = 5;
   localparam int        EDGE_LO       = 4;
   localparam int        OC_REC_BIT    = 3;
   localparam int        OT_REC_BIT    = 2;
   localparam int        R_MIX_BIT     = 1;
   localparam int        L_MIX_BIT     = 0;
   localparam logic [7:0] GAIN_RESET   = 8'h22;
   localparam logic [7:0] MODE_RESET   = 8'h0C;
   localparam logic [7:0] MODE_WR_MASK = 8'h3F;
   localparam logic [5:0] GAIN_SAT     = 6'h2E;
endpackage : amp_regs_pkg

`default_nettype wire

// file: hdl/gain_effective.sv
// one channel's applied gain code, clamped to the top of the gain range
// assumes the source code is already chosen by the register bank
`default_nettype none

module gain_effective #(
   parameter int CODE_W = 6
) (
   input  wire logic              mclk_in,
   input  wire logic              nrst_in,
   input  wire logic [CODE_W-1:0] code_in,
   output var  logic [CODE_W-1:0] code_out
);
   // ---------------------------------------------------------------
   // width check
   // ---------------------------------------------------------------
   generate
      if (CODE_W != amp_regs_pkg::CODE_W) begin : g_bad_width
         $error("gain_effective: code width must be six bits");
      end
   endgenerate

   // ---------------------------------------------------------------
   // clamp
   // ---------------------------------------------------------------
   // codes above the top step all give the same gain, so clamp them
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         code_out <= amp_regs_pkg::GAIN_RESET[CODE_W-1:0];
      end else if (code_in > amp_regs_pkg::GAIN_SAT) begin
         code_out <= amp_regs_pkg::GAIN_SAT;
      end else begin
         code_out <= code_in;
      end
   end
endmodule : gain_effective

`default_nettype wire

// file: verification/serial_host_model.sv
// behavioural two-wire host: turns a send request into one write word
// assumes the bench raises send_in for one cycle per word
`default_nettype none

module serial_host_model #(
   parameter logic [6:0] BUS_ADDR = 7'h31
) (
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic        send_in,
   input  wire logic        raw_in,
   input  wire logic [6:0]  addr_in,
   input  wire logic [8:0]  data_in,
   output var  logic        wr_valid_out,
   output var  logic [15:0] wr_word_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // address byte that opens every write transfer on the wire
   localparam logic [7:0] WRITE_BYTE = {BUS_ADDR, 1'b0};

   logic [8:0] data_sent;

   // fixed-zero mode bits go out as zero unless a fault is commanded
   always_comb begin
      data_sent = data_in;
      if (!raw_in && addr_in == amp_regs_pkg::ADDR_MODE) begin
         data_sent[7:6] = 2'b00;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         wr_valid_out <= 1'b0;
         wr_word_out  <= 16'h0000;
      end else if (send_in) begin
         wr_valid_out <= 1'b1;
         wr_word_out  <= {addr_in, data_sent};
      end else begin
         wr_valid_out <= 1'b0;
         // released between words: never leave a stale word standing
         wr_word_out  <= ~wr_word_out;
      end
   end
endmodule : serial_host_model

`default_nettype wire

// file: verification/tb_amp_gain_mode_registers.sv
// self-checking bench for the gain and mode register bank
// assumes the host model sits between the bench and the write port
`default_nettype none

module tb_amp_gain_mode_registers;
   timeunit 1ns;
   timeprecision 1ps;

   logic       mclk_in = 1'b0;
   logic       nrst_in = 1'b0;
   logic       send = 1'b0;
   logic       raw = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [8:0] data = 9'h000;
   logic       wr_valid;
   logic [15:0] wr_word;
   logic [6:0] rd_addr = 7'h00;
   logic       lce = 1'b0;
   logic [8:0] rd_data;
   logic       lm, rm, oc, ot, rmix, lmix;
   logic [5:0] lc, rc;
   logic [1:0] edge_rate;
   int         mismatches = 0;
   int         n_checks = 0;
   int         cycles = 0;
   logic [5:0] sat_in [4] = '{6'h00, 6'h2D, 6'h2E, 6'h3F};
   logic [5:0] sat_ex [4] = '{6'h00, 6'h2D, 6'h2E, 6'h2E};

   always #10 mclk_in = ~mclk_in;

   serial_host_model host (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .send_in(send), .raw_in(raw), .addr_in(addr), .data_in(data),
      .wr_valid_out(wr_valid), .wr_word_out(wr_word));

   amp_gain_mode_registers dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .wr_valid_in(wr_valid), .wr_word_in(wr_word), .rd_addr_in(rd_addr),
      .level_control_enable_in(lce), .rd_data_out(rd_data),
      .left_channel_mute_out(lm), .right_channel_mute_out(rm),
      .left_gain_code_out(lc), .right_gain_code_out(rc),
      .edge_rate_out(edge_rate), .overcurrent_autorecovery_enable_out(oc),
      .overtemp_autorecovery_enable_out(ot),
      .right_input_to_both_mix_out(rmix), .left_input_to_both_mix_out(lmix));

   task automatic stop_test();
      if (mismatches == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // do_reset, wr, rd, chk_gain and chk_mode end in the time step of a rising edge; check runs 1 ns after one
   task automatic do_reset();
      nrst_in <= 1'b0;
      repeat (5) @(posedge mclk_in);
      nrst_in <= 1'b1;
      @(posedge mclk_in);
   endtask : do_reset

   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      send <= 1'b1;
      addr <= a;
      data <= d;
      @(posedge mclk_in);
      send <= 1'b0;
      @(posedge mclk_in);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [8:0] exp);
      rd_addr <= a;
      @(posedge mclk_in);
      #1 check(rd_data, exp);
      @(posedge mclk_in);
   endtask : rd

   // gain outputs lag the registers by one edge
   task automatic chk_gain(input logic m_l, input logic m_r,
                           input logic [5:0] c_l, input logic [5:0] c_r);
      @(posedge mclk_in);
      #1 check({1'b0, lm, rm, lc}, {1'b0, m_l, m_r, c_l});
      check({3'h0, rc}, {3'h0, c_r});
      @(posedge mclk_in);
   endtask : chk_gain

   task automatic chk_mode(input logic [5:0] exp);
      @(posedge mclk_in);
      #1 check({3'h0, edge_rate, oc, ot, rmix, lmix}, {3'h0, exp});
      @(posedge mclk_in);
   endtask : chk_mode

   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      do_reset();
      rd(7'h00, 9'h022);
      rd(7'h01, 9'h022);
      rd(7'h02, 9'h00C);
      chk_gain(1'b0, 1'b0, 6'h22, 6'h22);
      chk_mode(6'h0C);
      wr(7'h00, 9'h045);
      chk_gain(1'b1, 1'b0, 6'h05, 6'h22);
      rd(7'h01, 9'h022);
      wr(7'h00, 9'h090);
      rd(7'h01, 9'h010);
      chk_gain(1'b0, 1'b0, 6'h10, 6'h10);
      wr(7'h01, 9'h0C7);
      rd(7'h00, 9'h087);
      rd(7'h01, 9'h0C7);
      chk_gain(1'b0, 1'b1, 6'h07, 6'h07);
      for (int i = 0; i < 4; i++) begin
         wr(7'h00, {3'h0, sat_in[i]});
         wr(7'h01, {3'h0, sat_in[i]});
         chk_gain(1'b0, 1'b0, sat_ex[i], sat_ex[i]);
      end
      for (int e = 0; e < 4; e++) begin
         wr(7'h02, {3'h0, 2'(e), 4'hA});
         chk_mode({2'(e), 4'hA});
      end
      wr(7'h02, 9'h005);
      chk_mode(6'h05);
      raw <= 1'b1;
      wr(7'h02, 9'h1FF);
      raw <= 1'b0;
      rd(7'h02, 9'h03F);
      wr(7'h03, 9'h0FF);
      rd(7'h03, 9'h000);
      rd(7'h00, 9'h03F);
      wr(7'h01, 9'h010);
      lce <= 1'b1;
      chk_gain(1'b0, 1'b0, 6'h2E, 6'h2E);
      wr(7'h00, 9'h045);
      wr(7'h01, 9'h08A);
      rd(7'h00, 9'h07F);
      rd(7'h01, 9'h090);
      chk_gain(1'b1, 1'b0, 6'h2E, 6'h2E);
      lce <= 1'b0;
      chk_gain(1'b1, 1'b0, 6'h2E, 6'h10);
      do_reset();
      rd(7'h00, 9'h022);
      chk_mode(6'h0C);
      stop_test();
   end
endmodule : tb_amp_gain_mode_registers

`default_nettype wire
